// File: core/sector_map_detect.sv
// APB slave holding the sector-map detect descriptors and the live
// volatile configuration bytes they point at.
// Assumes an APB4 master on ref_clk; all inputs are synchronous to it.
//
// Notes on behaviour
// - The first command descriptor reads as bytes FCh,65h,FFh,08h from 1ECh upward.
// - The second command descriptor reads as bytes FCh,65h,FFh,40h from 1F4h upward.
// - The first detect reads address 00800004h, which returns config register three.
// - The second detect reads address 00800002h, which returns config register one.
// - Bit 1 of each command word is 0 for a command and bit 0 is 0 for more to follow.
// - Reserved bits 21:20 and 7:2 of each command word read as all ones.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module sector_map_detect
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             uniform_or_hybrid_select,
   output logic             small_sector_split_select,
   output logic             small_sector_top_select,
   output logic             map_index_valid
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0]  cfg_one;
      logic [7:0]  cfg_three;
      logic [31:0] reg_addr;
      logic [31:0] rdata;
      logic        slverr;
   } regs_s;

   regs_s state_q;
   regs_s state_d;

   logic [31:0] table_word;
   logic        table_hit;
   logic [2:0]  map_index;
   logic        index_ok;
   logic [31:0] reg_data;
   logic        setup_phase;
   logic        access_phase;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic is_rw_reg(input logic [11:0] a);
      return (a == sector_map_pkg::CFG_ONE_OFS) ||
             (a == sector_map_pkg::CFG_THREE_OFS) ||
             (a == sector_map_pkg::REG_ADDR_OFS);
   endfunction

   function automatic logic is_ro_reg(input logic [11:0] a);
      return (a == sector_map_pkg::REG_DATA_OFS) ||
             (a == sector_map_pkg::MAP_INDEX_OFS);
   endfunction

   function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                             input logic [7:0] wr,
                                             input logic       en);
      return en ? wr : old;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Constant table

   detect_desc_rom u_rom
   (
      .byte_addr  (paddr),
      .table_word (table_word),
      .table_hit  (table_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Live detect bits and read-any-register path

   always_comb
   begin
      map_index = {state_q.cfg_three[sector_map_pkg::UNIFORM_BIT],
                   state_q.cfg_one[sector_map_pkg::SPLIT_BIT],
                   state_q.cfg_one[sector_map_pkg::TOP_BIT]};
      index_ok  = (map_index == sector_map_pkg::INDEX_BOTTOM) ||
                  (map_index == sector_map_pkg::INDEX_TOP) ||
                  (map_index == sector_map_pkg::INDEX_SPLIT) ||
                  (map_index == sector_map_pkg::INDEX_UNIFORM);
   end

   // Byte returned for the register address software has loaded
   always_comb
   begin
      reg_data = 32'h00000000;
      if (state_q.reg_addr == sector_map_pkg::CFG_THREE_REG_ADDR)
      begin
         reg_data[7:0] = state_q.cfg_three;
         reg_data[sector_map_pkg::REG_HIT_BIT] = 1'b1;
      end
      else if (state_q.reg_addr == sector_map_pkg::CFG_ONE_REG_ADDR)
      begin
         reg_data[7:0] = state_q.cfg_one;
         reg_data[sector_map_pkg::REG_HIT_BIT] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: read data and error captured in setup, used in access

   assign setup_phase  = psel && !penable;
   assign access_phase = psel && penable;

   always_comb
   begin
      state_d = state_q;
      if (setup_phase)
      begin
         state_d.rdata  = 32'h00000000;
         state_d.slverr = 1'b0;
         if (pwrite)
         begin
            // Table and status words are read-only
            state_d.slverr = !is_rw_reg(paddr);
         end
         else if (table_hit)
         begin
            state_d.rdata = table_word;
         end
         else
         begin
            unique case (paddr)
               sector_map_pkg::CFG_ONE_OFS:
                  state_d.rdata = {24'h000000, state_q.cfg_one};
               sector_map_pkg::CFG_THREE_OFS:
                  state_d.rdata = {24'h000000, state_q.cfg_three};
               sector_map_pkg::REG_ADDR_OFS:
                  state_d.rdata = state_q.reg_addr;
               sector_map_pkg::REG_DATA_OFS:
                  state_d.rdata = reg_data;
               sector_map_pkg::MAP_INDEX_OFS:
                  state_d.rdata = {23'h000000, index_ok, 5'h00, map_index};
               default:
                  state_d.slverr = 1'b1;
            endcase
         end
      end
      else if (access_phase && pwrite && !state_q.slverr)
      begin
         unique case (paddr)
            sector_map_pkg::CFG_ONE_OFS:
               state_d.cfg_one = merge_byte(state_q.cfg_one, pwdata[7:0], pstrb[0]);
            sector_map_pkg::CFG_THREE_OFS:
               state_d.cfg_three = merge_byte(state_q.cfg_three, pwdata[7:0], pstrb[0]);
            sector_map_pkg::REG_ADDR_OFS:
            begin
               state_d.reg_addr[7:0]   = merge_byte(state_q.reg_addr[7:0],
                                                    pwdata[7:0], pstrb[0]);
               state_d.reg_addr[15:8]  = merge_byte(state_q.reg_addr[15:8],
                                                    pwdata[15:8], pstrb[1]);
               state_d.reg_addr[23:16] = merge_byte(state_q.reg_addr[23:16],
                                                    pwdata[23:16], pstrb[2]);
               state_d.reg_addr[31:24] = merge_byte(state_q.reg_addr[31:24],
                                                    pwdata[31:24], pstrb[3]);
            end
            default:
            begin
               state_d.reg_addr = state_q.reg_addr;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q.cfg_one   <= sector_map_pkg::CFG_ONE_RESET;
         state_q.cfg_three <= sector_map_pkg::CFG_THREE_RESET;
         state_q.reg_addr  <= sector_map_pkg::REG_ADDR_RESET;
         state_q.rdata     <= 32'h00000000;
         state_q.slverr    <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign pready  = 1'b1;
   assign prdata  = state_q.rdata;
   assign pslverr = access_phase && state_q.slverr;

   assign uniform_or_hybrid_select  = state_q.cfg_three[sector_map_pkg::UNIFORM_BIT];
   assign small_sector_split_select = state_q.cfg_one[sector_map_pkg::SPLIT_BIT];
   assign small_sector_top_select   = state_q.cfg_one[sector_map_pkg::TOP_BIT];
   assign map_index_valid           = index_ok;

endmodule

// File: core/sector_map_pkg.sv
// Constants for the sector-map configuration-detect table block.
// Assumes an APB4 slave with 32-bit data and byte addresses on paddr.
package sector_map_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   ////////////////////////////////////////////////////////////////////////////
   // Constant detect table, byte addresses
   localparam logic [11:0] DETECT_ONE_COMMAND_WORD_OFS = 12'h1ec;
   localparam logic [11:0] DETECT_ONE_ADDRESS_WORD_OFS = 12'h1f0;
   localparam logic [11:0] DETECT_TWO_COMMAND_WORD_OFS = 12'h1f4;
   localparam logic [11:0] DETECT_TWO_ADDRESS_WORD_OFS = 12'h1f8;

   // Software-visible control and status registers
   localparam logic [11:0] CFG_ONE_OFS      = 12'h000;
   localparam logic [11:0] CFG_THREE_OFS    = 12'h004;
   localparam logic [11:0] REG_ADDR_OFS     = 12'h008;
   localparam logic [11:0] REG_DATA_OFS     = 12'h00c;
   localparam logic [11:0] MAP_INDEX_OFS    = 12'h010;

   ////////////////////////////////////////////////////////////////////////////
   // Command descriptor fields
   localparam int unsigned DESC_MASK_LSB     = 24;
   localparam int unsigned DESC_ADDR_LEN_LSB = 22;
   localparam int unsigned DESC_RSVD_HI_LSB  = 20;
   localparam int unsigned DESC_LATENCY_LSB  = 16;
   localparam int unsigned DESC_INSTR_LSB    = 8;
   localparam int unsigned DESC_RSVD_LO_LSB  = 2;
   localparam int unsigned DESC_TYPE_BIT     = 1;
   localparam int unsigned DESC_END_BIT      = 0;

   localparam logic [7:0] READ_ANY_REG_INSTR = 8'h65;
   localparam logic [1:0] ADDR_LEN_VARIABLE  = 2'h3;
   localparam logic [1:0] RSVD_HI_VALUE      = 2'h3;
   localparam logic [3:0] LATENCY_VARIABLE   = 4'hf;
   localparam logic [5:0] RSVD_LO_VALUE      = 6'h3f;
   localparam logic       DESC_IS_COMMAND    = 1'b0;
   localparam logic       DESC_MORE_FOLLOW   = 1'b0;

   localparam logic [7:0] DETECT_ONE_MASK = 8'h08;
   localparam logic [7:0] DETECT_TWO_MASK = 8'h40;

   ////////////////////////////////////////////////////////////////////////////
   // Volatile configuration register addresses on the read-any-register path
   localparam logic [31:0] CFG_THREE_REG_ADDR = 32'h00800004;
   localparam logic [31:0] CFG_ONE_REG_ADDR   = 32'h00800002;

   // Bit positions feeding the map index, plus the register hit and index valid flags
   localparam int unsigned UNIFORM_BIT   = 3;
   localparam int unsigned SPLIT_BIT     = 6;
   localparam int unsigned TOP_BIT       = 2;
   localparam int unsigned REG_HIT_BIT   = 8;
   localparam int unsigned INDEX_OK_BIT  = 8;

   // Supported map index values
   localparam logic [2:0] INDEX_BOTTOM  = 3'h0;
   localparam logic [2:0] INDEX_TOP     = 3'h1;
   localparam logic [2:0] INDEX_SPLIT   = 3'h2;
   localparam logic [2:0] INDEX_UNIFORM = 3'h4;

   // Reset values
   localparam logic [7:0]  CFG_ONE_RESET   = 8'h00;
   localparam logic [7:0]  CFG_THREE_RESET = 8'h00;
   localparam logic [31:0] REG_ADDR_RESET  = 32'h00000000;

endpackage

// File: core/detect_desc_rom.sv
// Constant lookup of the configuration-detect descriptor words.
// Assumes a byte address from the bus side; only aligned words hit.
`timescale 1ns/1ps
module detect_desc_rom
(
   input  wire logic [11:0] byte_addr,
   output logic      [31:0] table_word,
   output logic             table_hit
);

   function automatic logic [31:0] command_word(input logic [7:0] mask);
      logic [31:0] w;
      w = 32'h00000000;
      w[31:24] = mask;
      w[23:22] = sector_map_pkg::ADDR_LEN_VARIABLE;
      w[21:20] = sector_map_pkg::RSVD_HI_VALUE;
      w[19:16] = sector_map_pkg::LATENCY_VARIABLE;
      w[15:8]  = sector_map_pkg::READ_ANY_REG_INSTR;
      w[7:2]   = sector_map_pkg::RSVD_LO_VALUE;
      w[sector_map_pkg::DESC_TYPE_BIT] = sector_map_pkg::DESC_IS_COMMAND;
      w[sector_map_pkg::DESC_END_BIT]  = sector_map_pkg::DESC_MORE_FOLLOW;
      return w;
   endfunction

   // Contents never depend on live configuration
   always_comb
   begin
      table_hit  = 1'b1;
      table_word = 32'h00000000;
      unique case (byte_addr)
         sector_map_pkg::DETECT_ONE_COMMAND_WORD_OFS:
            table_word = command_word(sector_map_pkg::DETECT_ONE_MASK);
         sector_map_pkg::DETECT_ONE_ADDRESS_WORD_OFS:
            table_word = sector_map_pkg::CFG_THREE_REG_ADDR;
         sector_map_pkg::DETECT_TWO_COMMAND_WORD_OFS:
            table_word = command_word(sector_map_pkg::DETECT_TWO_MASK);
         sector_map_pkg::DETECT_TWO_ADDRESS_WORD_OFS:
            table_word = sector_map_pkg::CFG_ONE_REG_ADDR;
         default:
            table_hit = 1'b0;
      endcase
   end

endmodule

// File: sim/smd_asserts.sv
// Port assertions for the sector-map detect slave.
// Assumes binding onto sector_map_detect, APB on ref_clk.
`timescale 1ns/1ps
module smd_asserts
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        uniform_or_hybrid_select,
   input wire logic        small_sector_split_select,
   input wire logic        small_sector_top_select,
   input wire logic        map_index_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire       rd = psel && !penable && !pwrite;
   wire       wr = psel && penable && pwrite && pstrb[0];
   wire [2:0] ix = {uniform_or_hybrid_select, small_sector_split_select,
                    small_sector_top_select};
   ////////////////////////////////////////////////////////////////////////////
   property p_one; rd && paddr == 12'h1ec |=> prdata == 32'h08ff65fc; endproperty
   a_one: assert property (p_one) else $error("word 1ec wrong");
   property p_adr1; rd && paddr == 12'h1f0 |=> prdata == 32'h00800004; endproperty
   a_adr1: assert property (p_adr1) else $error("word 1f0 wrong");
   property p_two; rd && paddr == 12'h1f4 |=> prdata == 32'h40ff65fc; endproperty
   a_two: assert property (p_two) else $error("word 1f4 wrong");
   property p_adr2; rd && paddr == 12'h1f8 |=> prdata == 32'h00800002; endproperty
   a_adr2: assert property (p_adr2) else $error("word 1f8 wrong");
   property p_fld;
      rd && (paddr == 12'h1ec || paddr == 12'h1f4) |=> prdata[23:0] == 24'hff65fc;
   endproperty
   a_fld: assert property (p_fld) else $error("descriptor fields wrong");
   property p_uni;
      wr && paddr == 12'h004 |=> uniform_or_hybrid_select == $past(pwdata[3]);
   endproperty
   a_uni: assert property (p_uni) else $error("uniform select wrong");
   property p_spl;
      wr && paddr == 12'h000 |=> ix[1:0] == {$past(pwdata[6]), $past(pwdata[2])};
   endproperty
   a_spl: assert property (p_spl) else $error("split or top select wrong");
   property p_val; map_index_valid == (ix inside {3'h0, 3'h1, 3'h2, 3'h4}); endproperty
   a_val: assert property (p_val) else $error("index valid wrong");
   property p_err;
      psel && penable && pwrite && paddr >= 12'h1ec && paddr <= 12'h1f8 |-> pslverr;
   endproperty
   a_err: assert property (p_err) else $error("table write not refused");
   c_rd: cover property (rd && paddr == 12'h1f8);
   c_uni: cover property ($rose(uniform_or_hybrid_select));
   c_bad: cover property (!map_index_valid);
   c_err: cover property (psel && penable && pslverr);
endmodule

bind sector_map_detect smd_asserts u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pslverr, .uniform_or_hybrid_select,
   .small_sector_split_select, .small_sector_top_select, .map_index_valid);

// File: sim/flash_host_model.sv
// Host model: APB master and the sector-map detect sequence.
// Assumes tasks are entered right after a rising edge of ref_clk.
`timescale 1ns/1ps
module flash_host_model
(
   input  wire logic        ref_clk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
         @(posedge ref_clk);
      r = prdata;
      e = pslverr;
      penable <= 1'b0;
   endtask
   task automatic idle();
      psel <= 1'b0;
      @(posedge ref_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Two table-driven detect steps, then the top bit; builds the map index
   task automatic detect(output logic [2:0] idx, output logic bad);
      logic [31:0] cmd;
      logic [31:0] adr;
      logic [31:0] b;
      logic        e;
      bad = 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         cmd = 32'h04ff65fd;
         adr = 32'h00800002;
         if (k < 2)
         begin
            xfer(1'b0, 12'h1ec + 12'(8 * k), 32'h0, cmd, e);
            xfer(1'b0, 12'h1f0 + 12'(8 * k), 32'h0, adr, e);
         end
         if (cmd[23:8] !== 16'hff65 || cmd[1] !== 1'b0)
            bad = 1'b1;
         xfer(1'b1, 12'h008, adr, b, e);
         xfer(1'b0, 12'h00c, 32'h0, b, e);
         idx[2 - k] = |(b[7:0] & cmd[31:24]);
      end
      if (!(idx inside {3'h0, 3'h1, 3'h2, 3'h4}))
         bad = 1'b1;
      idle();
   endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the sector-map detect slave.
// Assumes the host model drives APB and the checker is bound.
`timescale 1ns/1ps
`define CHK(g, x) \
   begin \
      n_checks++; \
      if ((g) !== (x)) \
      begin \
         num_errors++; \
         $display("Error at %0t: got %h want %h", $time, g, x); \
      end \
   end
module tb_top;
   localparam logic [31:0] TAB [4] = '{32'h08ff65fc, 32'h00800004, 32'h40ff65fc,
                                       32'h00800002};
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, e, bad;
   logic        uni, spl, top, valid;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0]  pstrb;
   logic [7:0]  c1, c3;
   logic [2:0]  idx, ex;
   int          num_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   always #2 ref_clk = ~ref_clk;
   sector_map_detect DUT (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .uniform_or_hybrid_select(uni),
      .small_sector_split_select(spl), .small_sector_top_select(top),
      .map_index_valid(valid));
   flash_host_model u_host (.ref_clk, .prdata, .pready, .pslverr, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb);
   function automatic logic ok(input logic [2:0] i);
      return i inside {3'h0, 3'h1, 3'h2, 3'h4};
   endfunction
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         num_errors++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h1f1cf5bd));
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++)
      begin
         u_host.xfer(1'b1, 12'h000, $urandom, r, e);
         u_host.xfer(1'b1, 12'h004, $urandom, r, e);
         for (int k = 0; k < 4; k++)
         begin
            u_host.xfer(1'b0, 12'h1ec + 12'(4 * k), 32'h0, r, e);
            `CHK(r, TAB[k])
            `CHK(e, 1'b0)
         end
      end
      $display("Table test done");
      for (int i = 0; i < 12; i++)
      begin
         c1 = 8'($urandom);
         c3 = 8'($urandom);
         if (i < 8)
            {c3[3], c1[6], c1[2]} = 3'(i);
         ex = {c3[3], c1[6], c1[2]};
         u_host.xfer(1'b1, 12'h000, {24'h0, c1}, r, e);
         u_host.xfer(1'b1, 12'h004, {24'h0, c3}, r, e);
         u_host.xfer(1'b0, 12'h010, 32'h0, r, e);
         `CHK(r, {23'h0, ok(ex), 5'h0, ex})
         u_host.detect(idx, bad);
         `CHK(idx, ex)
         `CHK({bad, uni, spl, top, valid}, {!ok(ex), ex, ok(ex)})
      end
      $display("Detect test done");
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      `CHK({uni, spl, top, valid}, 4'h1)
      u_host.xfer(1'b0, 12'h004, 32'h0, r, e);
      `CHK(r, 32'h0)
      u_host.xfer(1'b1, 12'h1ec, $urandom, r, e);
      `CHK(e, 1'b1)
      u_host.xfer(1'b0, 12'h1ec, 32'h0, r, e);
      `CHK(r, TAB[0])
      u_host.xfer(1'b1, 12'h008, 32'h00800003, r, e);
      u_host.xfer(1'b0, 12'h00c, 32'h0, r, e);
      `CHK(r, 32'h0)
      u_host.idle();
      $display("Refusal test done");
      end_sim();
   end
endmodule
